/* core/tmr8_timer.sv */
// tmr8_timer: 8-bit timer/counter with prescaler shared with the watchdog.
// assumes ext_count_input and sleep are synchronous to ref_clk and the
// register port master follows the one-cycle strobe protocol.
module tmr8_timer
  import tmr8_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  // device context
  input wire logic ext_count_input,
  input wire logic sleep,
  input wire logic watchdog_clear_instr,
  // watchdog side of the shared prescaler
  output logic watchdog_tick,
  // interrupt outputs
  output logic timer_irq_req,
  output logic irq
);

  typedef enum logic [2:0] {
    ST_RUN = 3'h1,
    ST_HOLD1 = 3'h2,
    ST_HOLD2 = 3'h4
  } tmr8_inh_t;

  tmr8_req_t req;
  tmr8_cfg_t cfg;
  tmr8_inh_t inh_ff;
  tmr8_inh_t nxt_inh;

  logic [DATA_W-1:0] option_ff;
  logic [DATA_W-1:0] ictl_ff;
  logic [DATA_W-1:0] count_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic [EVT_W-1:0] status_ff;
  logic [EVT_W-1:0] mask_ff;
  logic [1:0] phase_ff;
  logic pin_q2_ff;
  logic pin_q4_ff;
  logic pin_prev_ff;
  logic presc_sync_ff;

  logic instr_tick;
  logic phase_two;
  logic phase_four;
  logic ext_edge;
  logic src_tick;
  logic presc_in;
  logic presc_out;
  logic presc_clr;
  logic timer_in;
  logic inc;
  logic wrap;
  logic count_wr;
  logic [EVT_W-1:0] evt;
  logic [RATE_W-1:0] presc_tap;
  logic [DATA_W-1:0] nxt_rdata;

  // a write strobe aimed at one register index
  function automatic logic is_wr(input tmr8_req_t r, input logic [ADDR_W-1:0] a);
    is_wr = r.wr && (r.addr == a);
  endfunction

  // prev and cur are successive phase-four samples of the pin
  function automatic logic pin_edge(input logic prev, input logic cur, input logic fall);
    pin_edge = fall ? (prev && !cur) : (!prev && cur);
  endfunction

  // the watchdog side is one tap shorter than the timer for the same code;
  // code 000 bypasses the counter there, so its tap is left as it is
  function automatic logic [RATE_W-1:0] tap_of(input tmr8_cfg_t c);
    if (c.to_wdt && (c.rate != '0)) begin
      tap_of = c.rate - RATE_W'(1);
    end else begin
      tap_of = c.rate;
    end
  endfunction

  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
  assign cfg = '{src_ext: option_ff[OPT_SRC_BIT],
                 edge_fall: option_ff[OPT_EDGE_BIT],
                 to_wdt: option_ff[OPT_PSA_BIT],
                 rate: option_ff[OPT_RATE_LSB +: RATE_W]};
  assign count_wr = is_wr(req, REG_COUNT);

  // phase counter: four core clocks per instruction cycle
  // it keeps running in sleep; only the count, the prescaler and the watchdog tick freeze
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      phase_ff <= '0;
    end else begin
      phase_ff <= phase_ff + 2'h1;
    end
  end

  assign phase_two = (phase_ff == PH_TWO);
  assign phase_four = (phase_ff == PH_FOUR);
  assign instr_tick = phase_four;

  // pin taken on phase two, then handed on at phase four: two-stage resync
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pin_q2_ff <= 1'b0;
    end else if (phase_two) begin
      pin_q2_ff <= ext_count_input;
    end
  end

  // a level must last past one phase two and one phase four to be counted
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pin_q4_ff <= 1'b0;
      pin_prev_ff <= 1'b0;
    end else if (phase_four) begin
      pin_prev_ff <= pin_q4_ff;
      pin_q4_ff <= pin_q2_ff;
    end
  end

  // edge select: compare successive phase-four samples
  assign ext_edge = phase_four && pin_edge(pin_prev_ff, pin_q4_ff, cfg.edge_fall);

  // source select
  assign src_tick = cfg.src_ext ? ext_edge : instr_tick;

  // prescaler input: timer source when assigned to timer, else watchdog base
  assign presc_in = cfg.to_wdt ? instr_tick : src_tick;
  assign presc_clr = (count_wr && !cfg.to_wdt)
                  || (watchdog_clear_instr && cfg.to_wdt);

  // one counter serves both users; its input, clear and tap differ between them
  assign presc_tap = tap_of(cfg);

  tmr8_prescaler #(
    .WIDTH(PRESC_W)
  ) u_presc (
    .ref_clk(ref_clk),
    .rst(rst),
    .clr(presc_clr),
    .tick(presc_in && !sleep),
    .tap(presc_tap),
    .out_tick(presc_out)
  );

  // prescaler output resampled on phase two before reaching the count register
  // held from phase four until the next phase two, so no output pulse is lost
  always_ff @(posedge ref_clk) begin
    if (rst || presc_clr) begin
      presc_sync_ff <= 1'b0;
    end else if (presc_out) begin
      presc_sync_ff <= 1'b1;
    end else if (phase_two) begin
      presc_sync_ff <= 1'b0;
    end
  end

  // code 000 is 1:1 on the watchdog side, so the counter is bypassed there
  assign watchdog_tick = cfg.to_wdt
                      && !sleep
                      && ((cfg.rate == '0) ? instr_tick : presc_out);

  // with the prescaler on the watchdog the timer counts its source undivided
  assign timer_in = cfg.to_wdt ? src_tick : (presc_sync_ff && phase_two);

  // write inhibit over the two following instruction cycles
  always_comb begin
    nxt_inh = inh_ff;
    unique case (inh_ff)
      ST_RUN: nxt_inh = ST_RUN;
      ST_HOLD1: if (instr_tick) nxt_inh = ST_HOLD2;
      ST_HOLD2: if (instr_tick) nxt_inh = ST_RUN;
      default: nxt_inh = ST_RUN;
    endcase
    if (count_wr) begin
      nxt_inh = ST_HOLD1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      inh_ff <= ST_RUN;
    end else begin
      inh_ff <= nxt_inh;
    end
  end

  // a write in the same cycle takes priority, so a new value is never bumped
  assign inc = timer_in && !sleep && (inh_ff == ST_RUN) && !count_wr;
  assign wrap = inc && (count_ff == COUNT_MAX);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      count_ff <= COUNT_RST;
    end else if (count_wr) begin
      count_ff <= req.wdata;
    end else if (inc) begin
      count_ff <= count_ff + 8'h01;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      option_ff <= OPTION_RST;
    end else if (is_wr(req, REG_OPTION)) begin
      option_ff <= req.wdata;
    end
  end

  // overflow flag: set wins over a software clear in the same cycle
  // the other bits are plain storage; only the flag has a hardware setter
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ictl_ff <= ICTL_RST;
    end else begin
      if (is_wr(req, REG_INTCTL)) begin
        ictl_ff <= req.wdata;
      end
      if (wrap) begin
        ictl_ff[ICTL_IF_BIT] <= 1'b1;
      end
    end
  end

  assign timer_irq_req = ictl_ff[ICTL_IF_BIT] && ictl_ff[ICTL_IE_BIT];

  // sticky event status, write one to clear, set wins
  // the watchdog tick is only reported here; the watchdog itself lies outside
  assign evt = {watchdog_tick, wrap};

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      status_ff <= '0;
    end else if (is_wr(req, REG_IRQ_STATUS)) begin
      status_ff <= (status_ff & ~req.wdata[EVT_W-1:0]) | evt;
    end else begin
      status_ff <= status_ff | evt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mask_ff <= '0;
    end else if (is_wr(req, REG_IRQ_MASK)) begin
      mask_ff <= req.wdata[EVT_W-1:0];
    end
  end

  assign irq = |(status_ff & mask_ff);

  // read data valid the cycle after the strobe; unmapped reads return zero
  // zero outside the answer cycle, so read data of several blocks can be or-ed
  always_comb begin
    nxt_rdata = '0;
    if (req.rd) begin
      unique case (req.addr)
        REG_COUNT: nxt_rdata = count_ff;
        REG_OPTION: nxt_rdata = option_ff;
        REG_INTCTL: nxt_rdata = ictl_ff;
        REG_IRQ_STATUS: nxt_rdata = {{(DATA_W-EVT_W){1'b0}}, status_ff};
        REG_IRQ_MASK: nxt_rdata = {{(DATA_W-EVT_W){1'b0}}, mask_ff};
        default: nxt_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;

endmodule : tmr8_timer

/* core/tmr8_pkg.sv */
// tmr8_pkg: register indices, field positions, reset values and shared types
// for the 8-bit timer/counter with shared prescaler.
// assumes a single 250 MHz core clock; instruction cycle is four core clocks.
package tmr8_pkg;

  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;

  // register indices on the plain register port
  localparam logic [ADDR_W-1:0] REG_COUNT = 4'h0;
  localparam logic [ADDR_W-1:0] REG_OPTION = 4'h1;
  localparam logic [ADDR_W-1:0] REG_INTCTL = 4'h2;
  localparam logic [ADDR_W-1:0] REG_IRQ_STATUS = 4'h3;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 4'h4;

  // option register fields
  localparam int unsigned OPT_SRC_BIT = 5;
  localparam int unsigned OPT_EDGE_BIT = 4;
  localparam int unsigned OPT_PSA_BIT = 3;
  localparam int unsigned OPT_RATE_LSB = 0;
  localparam int unsigned RATE_W = 3;
  localparam logic [DATA_W-1:0] OPTION_RST = 8'hFF;

  // interrupt control fields
  localparam int unsigned ICTL_IE_BIT = 5;
  localparam int unsigned ICTL_IF_BIT = 2;
  localparam logic [DATA_W-1:0] ICTL_RST = 8'h00;
  localparam logic [DATA_W-1:0] ICTL_RW_MASK = 8'hFB;

  // event status bits
  localparam int unsigned EVT_W = 2;
  localparam int unsigned EVT_OVF_BIT = 0;
  localparam int unsigned EVT_WDT_BIT = 1;

  localparam logic [DATA_W-1:0] COUNT_RST = 8'h00;
  localparam logic [DATA_W-1:0] COUNT_MAX = 8'hFF;

  // instruction cycle: four phases per cycle
  localparam int unsigned PHASES = 4;
  localparam logic [1:0] PH_TWO = 2'h1;
  localparam logic [1:0] PH_FOUR = 2'h3;
  localparam int unsigned WR_INHIBIT_CYC = 2;
  localparam int unsigned PRESC_W = 8;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } tmr8_req_t;

  typedef struct packed {
    logic src_ext;
    logic edge_fall;
    logic to_wdt;
    logic [RATE_W-1:0] rate;
  } tmr8_cfg_t;

endpackage : tmr8_pkg

/* core/tmr8_prescaler.sv */
// tmr8_prescaler: shared 8-bit ripple-style prescaler, power-of-two tap.
// assumes the caller provides a one-cycle input tick and a synchronous clear.
module tmr8_prescaler
  import tmr8_pkg::*;
#(
  parameter int unsigned WIDTH = PRESC_W
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // control
  input wire logic clr,
  input wire logic tick,
  input wire logic [RATE_W-1:0] tap,
  // output pulse, one cycle per 2**(tap+1) ticks
  output logic out_tick
);

  logic [WIDTH-1:0] cnt_ff;
  logic [WIDTH-1:0] nxt_cnt;

  assign nxt_cnt = cnt_ff + {{(WIDTH-1){1'b0}}, 1'b1};

  always_ff @(posedge ref_clk) begin
    if (rst || clr) begin
      cnt_ff <= '0;
    end else if (tick) begin
      cnt_ff <= nxt_cnt;
    end
  end

  // a tap bit falling from one to zero marks the division boundary
  assign out_tick = tick && cnt_ff[tap] && !nxt_cnt[tap];

endmodule : tmr8_prescaler

/* dv/tmr8_sva.sv */
// tmr8_sva: port-level checker for the timer/counter top module.
// assumes one clock domain and a synchronous active-high reset.
module tmr8_chk
  import tmr8_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  // device context and outputs
  input wire logic ext_count_input,
  input wire logic sleep,
  input wire logic watchdog_clear_instr,
  input wire logic watchdog_tick,
  input wire logic timer_irq_req,
  input wire logic irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // shadow of the option register, since only the ports are visible
  logic [DATA_W-1:0] opt_ff;
  always_ff @(posedge ref_clk) begin
    if (rst) opt_ff <= OPTION_RST;
    else if (reg_wr && reg_addr == REG_OPTION) opt_ff <= reg_wdata;
  end
  a_req_both: assert property (reg_rd && reg_addr == REG_INTCTL |=>
    (reg_rdata[ICTL_IE_BIT] && reg_rdata[ICTL_IF_BIT]) == $past(timer_irq_req))
    else $error("irq request differs from flag and enable");
  a_opt_rw: assert property (reg_wr && reg_addr == REG_OPTION ##1
    reg_rd && reg_addr == REG_OPTION |=> reg_rdata == $past(reg_wdata, 2))
    else $error("option readback differs from write");
  a_count_hold: assert property (reg_wr && reg_addr == REG_COUNT ##1
    reg_rd && reg_addr == REG_COUNT |=> reg_rdata == $past(reg_wdata, 2))
    else $error("count moved right after a write");
  a_sleep_frozen: assert property (sleep && !reg_wr |=> !$rose(timer_irq_req))
    else $error("overflow request rose in sleep");
  a_flag_sticky: assert property ($fell(timer_irq_req) |->
    $past(reg_wr && reg_addr == REG_INTCTL))
    else $error("overflow request fell with no write");
  a_irq_sticky: assert property ($fell(irq) |-> $past(reg_wr &&
    (reg_addr == REG_IRQ_STATUS || reg_addr == REG_IRQ_MASK)))
    else $error("irq fell with no status or mask write");
  a_wdt_assign: assert property (watchdog_tick |-> opt_ff[OPT_PSA_BIT])
    else $error("watchdog tick while prescaler on timer");
  a_wdt_gap: assert property (watchdog_tick |=> !watchdog_tick [*3])
    else $error("watchdog ticks closer than one instruction cycle");
endmodule // tmr8_chk

bind tmr8_timer tmr8_chk chk (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .ext_count_input(ext_count_input), .sleep(sleep),
  .watchdog_clear_instr(watchdog_clear_instr), .watchdog_tick(watchdog_tick),
  .timer_irq_req(timer_irq_req), .irq(irq));

/* dv/tmr8_count_src.sv */
// tmr8_count_src: behavioural source for the external count pin.
// assumes start is a one-cycle pulse given only while busy is low.
module tmr8_count_src (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // command
  input wire logic start,
  input wire logic [3:0] edges,
  input wire logic [7:0] half,
  // pin and status
  output logic ext_count_input,
  output logic busy
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    ext_count_input = 1'h0;
    busy = 1'h0;
  end
  // each level lasts half clocks, over one instruction cycle, so a
  // phase-four sample always lands on it; a run ends with the pin high
  always begin
    @(posedge ref_clk);
    if (start && !rst) begin
      busy <= 1'h1;
      repeat (edges) begin
        if (ext_count_input) begin
          ext_count_input <= 1'h0;
          repeat (half) @(posedge ref_clk);
        end
        ext_count_input <= 1'h1;
        repeat (half) @(posedge ref_clk);
      end
      busy <= 1'h0;
    end
  end
endmodule // tmr8_count_src

/* dv/tmr8_timer_bench.sv */
// tmr8_timer_bench: directed register-level tests of the timer/counter.
// assumes tmr8_count_src on the count pin and tmr8_chk bound to uut.
module tmr8_timer_bench;
  import tmr8_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'h0;
  logic rst = 1'h1;
  logic [ADDR_W-1:0] reg_addr = 4'h0;
  logic [DATA_W-1:0] reg_wdata = 8'h00;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic sleep = 1'h0;
  logic wclr = 1'h0;
  logic start = 1'h0;
  logic [7:0] half = 8'h08;
  logic [DATA_W-1:0] reg_rdata, v;
  logic ext, wtick, treq, irq, busy;
  int fails = 0;
  int checks = 0;
  int k, n;
  longint t0;
  always #2 ref_clk = ~ref_clk;
  tmr8_timer uut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_count_input(ext),
    .sleep(sleep), .watchdog_clear_instr(wclr), .watchdog_tick(wtick),
    .timer_irq_req(treq), .irq(irq));
  tmr8_count_src src (.ref_clk(ref_clk), .rst(rst), .start(start), .edges(4'h3),
    .half(half), .ext_count_input(ext), .busy(busy));
  task results;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task op(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    reg_wr <= w;
    reg_rd <= ~w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
  endtask
  task idle(input int c);
    reg_wr <= 1'h0;
    reg_rd <= 1'h0;
    repeat (c) @(posedge ref_clk);
  endtask
  task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    op(1'h1, a, d);
    idle(1);
  endtask
  task rdv(input logic [ADDR_W-1:0] a);
    op(1'h0, a, 8'h00);
    idle(0);
    #1 v = reg_rdata;
    @(posedge ref_clk);
  endtask
  task rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    rdv(a);
    chk(v, e);
  endtask
  // bounded wait: 0 irq high, 1 source idle
  task wait_on(input int sel, input int lim);
    for (k = 0; k <= lim; k++) begin
      @(posedge ref_clk);
      if ((sel == 0 && irq === 1'h1) || (sel == 1 && busy === 1'h0)) break;
    end
    if (k > lim) begin
      fails++;
      results();
    end
  endtask
  task step;
    logic [DATA_W-1:0] old;
    old = v;
    for (k = 0; k < 1500 && v === old; k++) rdv(REG_COUNT);
    if (v === old) begin
      fails++;
      results();
    end
  endtask
  task pulses(input logic [7:0] h);
    half <= h;
    start <= 1'h1;
    @(posedge ref_clk);
    start <= 1'h0;
    wait_on(1, 300);
    idle(12);
  endtask
  initial begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'h0;
    rd(REG_OPTION, OPTION_RST);
    rd(4'hF, 8'h00);
    op(1'h1, REG_OPTION, 8'h5A);
    rd(REG_OPTION, 8'h5A);
    $display("test registers done");
    wr(REG_OPTION, 8'h08);
    wr(REG_INTCTL, 8'h00);
    wr(REG_IRQ_MASK, 8'h01);
    op(1'h1, REG_COUNT, 8'hFE);
    rd(REG_COUNT, 8'hFE);
    wait_on(0, 40);
    chk({7'h00, treq}, 8'h00);
    rd(REG_INTCTL, 8'h04);
    wr(REG_INTCTL, 8'h24);
    chk({7'h00, treq}, 8'h01);
    repeat (1100) @(posedge ref_clk);
    rd(REG_INTCTL, 8'h24);
    wr(REG_INTCTL, 8'h20);
    chk({7'h00, treq}, 8'h00);
    wr(REG_IRQ_MASK, 8'h00);
    chk({7'h00, irq}, 8'h00);
    wr(REG_IRQ_MASK, 8'h01);
    chk({7'h00, irq}, 8'h01);
    wr(REG_IRQ_STATUS, 8'h01);
    chk({7'h00, irq}, 8'h00);
    $display("test overflow done");
    sleep <= 1'h1;
    wr(REG_COUNT, 8'hF0);
    idle(40);
    rd(REG_COUNT, 8'hF0);
    sleep <= 1'h0;
    $display("test sleep done");
    for (int r = 0; r < 8; r++) begin
      wclr <= 1'h1;
      @(posedge ref_clk);
      wclr <= 1'h0;
      wr(REG_OPTION, {5'h00, r[2:0]});
      wr(REG_COUNT, 8'h00);
      rdv(REG_COUNT);
      step();
      t0 = $time;
      step();
      chk(8'((($time - t0) / 4 + (4 << r)) / (8 << r)), 8'h01);
    end
    $display("test timer rates done");
    wr(REG_COUNT, 8'h00);
    wr(REG_OPTION, 8'h0F);
    for (int r = 0; r < 8; r++) begin
      wr(REG_OPTION, {5'h01, r[2:0]});
      n = 0;
      repeat (32 << r) begin
        @(posedge ref_clk);
        n += (wtick === 1'h1);
      end
      chk(8'(n >= 7 && n <= 9), 8'h01);
    end
    n = 0;
    repeat (8) begin
      wclr <= 1'h1;
      @(posedge ref_clk);
      wclr <= 1'h0;
      repeat (99) begin
        @(posedge ref_clk);
        n += (wtick === 1'h1);
      end
    end
    chk(8'(n), 8'h00);
    $display("test watchdog rates done");
    wr(REG_OPTION, 8'h38);
    wr(REG_COUNT, 8'h00);
    idle(12);
    pulses(8'h08);
    rd(REG_COUNT, 8'h02);
    wr(REG_OPTION, 8'h28);
    wr(REG_COUNT, 8'h00);
    idle(12);
    pulses(8'h14);
    rd(REG_COUNT, 8'h03);
    $display("test counter done");
    results();
  end
endmodule // tmr8_timer_bench
